// ==== rtl/desl_top.v ====
// dual edge event select and status with an axi4-lite control register
// What this block does
// - first sampling kind bit: 1 edge-sensitive, 0 level-sensitive for edge one
// - first polarity bit: 1 rising or high, 0 falling or low
// - first source: 0 timer, 1 compare, 2 pin two, 3 pin one, rest reserved
// - first event flag sets on a detected event, else keeps its value
// - software writes to first event flag control it directly, as for the second
// - second event flag sets on events; software writes control it directly
// - second sampling kind bit: 1 edge-sensitive, 0 level-sensitive
// - second polarity bit selects response independently of the first
// - implemented bits reset to zero; two lowest bits read zero
//
// Our own choices: the AXI4-Lite register port and the register offsets.
`include "desl_defines.vh"
module desl_top #(
   parameter ADDR_W = `DESL_ADDR_W
) (
   input  wire              aclk,
   input  wire              aresetn,
   input  wire [ADDR_W-1:0] s_axi_awaddr,
   input  wire              s_axi_awvalid,
   output wire              s_axi_awready,
   input  wire [31:0]       s_axi_wdata,
   input  wire [3:0]        s_axi_wstrb,
   input  wire              s_axi_wvalid,
   output wire              s_axi_wready,
   output wire [1:0]        s_axi_bresp,
   output wire              s_axi_bvalid,
   input  wire              s_axi_bready,
   input  wire [ADDR_W-1:0] s_axi_araddr,
   input  wire              s_axi_arvalid,
   output wire              s_axi_arready,
   output wire [31:0]       s_axi_rdata,
   output wire [1:0]        s_axi_rresp,
   output wire              s_axi_rvalid,
   input  wire              s_axi_rready,
   input  wire              timer_one_out,
   input  wire              output_compare_one,
   input  wire              input_capture_one,
   input  wire              comparator_one,
   input  wire              ext_edge_pin_one,
   input  wire              ext_edge_pin_two,
   output wire              first_event_flag,
   output wire              second_event_flag
);
   reg               aw_hold_q;
   reg [ADDR_W-1:0]  awaddr_q;
   reg               w_hold_q;
   reg [31:0]        wdata_q;
   reg [3:0]         wstrb_q;
   reg               bvalid_q;
   reg [1:0]         bresp_q;
   reg               rvalid_q;
   reg [31:0]        rdata_q;
   reg [1:0]         rresp_q;
   reg [15:0]        ctrl_q;
   reg               src1;
   reg               src2;
   wire              do_write;
   wire              wr_hit;
   wire [15:0]       wr_mask;
   wire [15:0]       ctrl_rd;
   wire [3:0]        sel1;
   wire [3:0]        sel2;
   wire              rd_hit;
   wire              stat1_wr;
   wire              stat2_wr;
   wire [15:0]       wr_word;

   // single register, so the word part of its byte address is all that decodes
   localparam [ADDR_W-1:0] CTRL_ADDR = `DESL_OFF_CTRL;

   // byte lane enables widened to a 16-bit mask
   function [15:0] lane_mask;
      input [3:0] strb;
      begin
         lane_mask = {{8{strb[1]}}, {8{strb[0]}}};
      end
   endfunction

   // word decode shared by the write and the read path
   function ctrl_addr_hit;
      input [ADDR_W-1:0] addr;
      begin
         ctrl_addr_hit = (addr[ADDR_W-1:2] == CTRL_ADDR[ADDR_W-1:2]);
      end
   endfunction

   // each address and data channel is latched independently, in either order
   assign s_axi_awready = ~aw_hold_q & ~bvalid_q;
   assign s_axi_wready  = ~w_hold_q & ~bvalid_q;
   assign do_write = aw_hold_q & w_hold_q & ~bvalid_q;
   assign wr_hit   = do_write & ctrl_addr_hit(awaddr_q);
   assign wr_mask  = lane_mask(wstrb_q) & `DESL_IMPL_MASK;
   assign wr_word  = wdata_q[15:0];

   // a flag is written only when the strobe covers its byte
   assign stat1_wr = wr_hit & wr_mask[`DESL_BIT_STAT1];
   assign stat2_wr = wr_hit & wr_mask[`DESL_BIT_STAT2];

   // write path: response rises one cycle after the later half is taken
   always @(posedge aclk) begin
      if (!aresetn) begin
         aw_hold_q <= 1'b0;
         awaddr_q  <= {ADDR_W{1'b0}};
         w_hold_q  <= 1'b0;
         wdata_q   <= 32'h00000000;
         wstrb_q   <= 4'h0;
         bvalid_q  <= 1'b0;
         bresp_q   <= `DESL_RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_hold_q <= 1'b1;
            awaddr_q  <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_hold_q <= 1'b1;
            wdata_q  <= s_axi_wdata;
            wstrb_q  <= s_axi_wstrb;
         end
         if (do_write) begin
            aw_hold_q <= 1'b0;
            w_hold_q  <= 1'b0;
            bvalid_q  <= 1'b1;
            bresp_q   <= wr_hit ? `DESL_RESP_OKAY : `DESL_RESP_SLVERR;
         end else if (bvalid_q && s_axi_bready) begin
            bvalid_q <= 1'b0;
         end
      end
   end

   // response outputs come straight from their registers
   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp  = bresp_q;

   // control bits other than the two flags; flags live in the channels
   always @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_q <= `DESL_CTRL_RESET;
      end else if (wr_hit) begin
         ctrl_q <= (ctrl_q & ~wr_mask) | (wr_word & wr_mask);
      end
   end

   assign sel1 = ctrl_q[`DESL_SEL1_HI:`DESL_SEL1_LO];
   assign sel2 = ctrl_q[`DESL_SEL2_HI:`DESL_SEL2_LO];

   // first source mux; reserved codes select a quiet low input
   // a source switch leaves the old sample in the synchroniser for two cycles,
   // so a level-mode setting may set its flag once; clear the flag after switching
   always @* begin
      case (sel1)
         `DESL_SRC1_TIMER: src1 = timer_one_out;
         `DESL_SRC1_OC:    src1 = output_compare_one;
         `DESL_SRC1_PIN2:  src1 = ext_edge_pin_two;
         `DESL_SRC1_PIN1:  src1 = ext_edge_pin_one;
         default:          src1 = 1'b0;
      endcase
   end

   // second source mux, same scheme with its own code table
   always @* begin
      case (sel2)
         `DESL_SRC2_IC:    src2 = input_capture_one;
         `DESL_SRC2_OC:    src2 = output_compare_one;
         `DESL_SRC2_PIN1:  src2 = ext_edge_pin_one;
         `DESL_SRC2_CMP:   src2 = comparator_one;
         default:          src2 = 1'b0;
      endcase
   end

   desl_edge_chan u_chan1 (
      .aclk             (aclk),
      .aresetn          (aresetn),
      .src_in           (src1),
      .sampling_kind    (ctrl_q[`DESL_BIT_MOD1]),
      .trigger_polarity (ctrl_q[`DESL_BIT_POL1]),
      .wr_en            (stat1_wr),
      .wr_val           (wr_word[`DESL_BIT_STAT1]),
      .event_flag       (first_event_flag)
   );

   desl_edge_chan u_chan2 (
      .aclk             (aclk),
      .aresetn          (aresetn),
      .src_in           (src2),
      .sampling_kind    (ctrl_q[`DESL_BIT_MOD2]),
      .trigger_polarity (ctrl_q[`DESL_BIT_POL2]),
      .wr_en            (stat2_wr),
      .wr_val           (wr_word[`DESL_BIT_STAT2]),
      .event_flag       (second_event_flag)
   );

   // readback merges live flags; lowest two bits are held at zero
   assign ctrl_rd = {ctrl_q[`DESL_BIT_MOD1:`DESL_SEL1_LO], second_event_flag, first_event_flag,
                     ctrl_q[`DESL_BIT_MOD2:`DESL_SEL2_LO], 2'b00};

   // read channel: one read at a time, answered the cycle after acceptance
   assign s_axi_arready = ~rvalid_q;

   assign rd_hit = ctrl_addr_hit(s_axi_araddr);

   always @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_q <= 1'b0;
         rdata_q  <= 32'h00000000;
         rresp_q  <= `DESL_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         rvalid_q <= 1'b1;
         if (rd_hit) begin
            rdata_q <= {16'h0000, ctrl_rd};
            rresp_q <= `DESL_RESP_OKAY;
         end else begin
            rdata_q <= 32'h00000000;
            rresp_q <= `DESL_RESP_SLVERR;
         end
      end else if (rvalid_q && s_axi_rready) begin
         rvalid_q <= 1'b0;
      end
   end

   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rdata  = rdata_q;
   assign s_axi_rresp  = rresp_q;
endmodule

// ==== rtl/desl_defines.vh ====
// constants for the dual edge event select and status block
`ifndef DESL_DEFINES_VH
`define DESL_DEFINES_VH
`define DESL_ADDR_W         4
`define DESL_OFF_CTRL       4'h0
`define DESL_CTRL_RESET     16'h0000
`define DESL_BIT_MOD1       15
`define DESL_BIT_POL1       14
`define DESL_SEL1_HI        13
`define DESL_SEL1_LO        10
`define DESL_BIT_STAT2      9
`define DESL_BIT_STAT1      8
`define DESL_BIT_MOD2       7
`define DESL_BIT_POL2       6
`define DESL_SEL2_HI        5
`define DESL_SEL2_LO        2
`define DESL_IMPL_MASK      16'hFFFC
`define DESL_SRC1_TIMER     4'h0
`define DESL_SRC1_OC        4'h1
`define DESL_SRC1_PIN2      4'h2
`define DESL_SRC1_PIN1      4'h3
`define DESL_SRC2_IC        4'h0
`define DESL_SRC2_OC        4'h1
`define DESL_SRC2_PIN1      4'h3
`define DESL_SRC2_CMP       4'h4
`define DESL_RESP_OKAY      2'h0
`define DESL_RESP_SLVERR    2'h2
`endif

// ==== rtl/desl_edge_chan.v ====
// one edge channel: synchroniser, edge or level detector, sticky state
module desl_edge_chan (
   input  wire aclk,
   input  wire aresetn,
   input  wire src_in,
   input  wire sampling_kind,
   input  wire trigger_polarity,
   input  wire wr_en,
   input  wire wr_val,
   output wire event_flag
);
   reg sync1_q;
   reg sync2_q;
   reg prev_q;
   reg flag_q;
   wire pol_now;
   wire pol_prev;
   wire hit;
   reg [2:0] fill_q;
   wire primed;

   // two-stage synchroniser, first stage read only by the second
   always @(posedge aclk) begin
      if (!aresetn) begin
         sync1_q <= 1'b0;
         sync2_q <= 1'b0;
         prev_q  <= 1'b0;
      end else begin
         sync1_q <= src_in;
         sync2_q <= sync1_q;
         prev_q  <= sync2_q;
      end
   end

   // fold polarity in so one detector serves both senses
   assign pol_now  = trigger_polarity ? sync2_q : ~sync2_q;
   assign pol_prev = trigger_polarity ? prev_q : ~prev_q;
   // samples are trusted only once the chain has filled after reset;
   // a reset-low chain would otherwise look like a live low level
   always @(posedge aclk) begin
      if (!aresetn) begin
         fill_q <= 3'b000;
      end else begin
         fill_q <= {fill_q[1:0], 1'b1};
      end
   end

   assign primed = fill_q[2];
   assign hit = primed & (sampling_kind ? (pol_now & ~pol_prev) : pol_now);

   // detected event wins over a software write of zero in the same cycle
   always @(posedge aclk) begin
      if (!aresetn) begin
         flag_q <= 1'b0;
      end else if (hit) begin
         flag_q <= 1'b1;
      end else if (wr_en) begin
         flag_q <= wr_val;
      end
   end

   assign event_flag = flag_q;
endmodule

// ==== bench/desl_monitor.sv ====
// bus handshake and flag checker for the edge select block
module desl_monitor (
   input wire        aclk,
   input wire        aresetn,
   input wire        s_axi_awready,
   input wire        s_axi_wready,
   input wire        s_axi_bvalid,
   input wire        s_axi_bready,
   input wire        s_axi_arvalid,
   input wire        s_axi_arready,
   input wire        s_axi_rvalid,
   input wire        s_axi_rready,
   input wire [31:0] s_axi_rdata,
   input wire        first_event_flag,
   input wire        second_event_flag
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // responses stand until taken, and block new requests meanwhile
   a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("bvalid dropped early");
   a_write_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken during response");
   a_bvalid_clear: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("bvalid stuck");
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data moved");
   a_read_block: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken during answer");
   // unimplemented low bits never show up on the bus
   a_low_bits: assert property (s_axi_rvalid |-> s_axi_rdata[1:0] == 2'h0)
      else $error("low bits not zero");
   a_flags_reset: assert property ($rose(aresetn) |-> !first_event_flag && !second_event_flag)
      else $error("flag set out of reset");
endmodule

bind desl_top desl_monitor u_desl_monitor (.aclk(aclk), .aresetn(aresetn), .s_axi_awready(s_axi_awready),
   .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata), .first_event_flag(first_event_flag),
   .second_event_flag(second_event_flag));

// ==== bench/desl_far_model.sv ====
// far-side sources: timer, compare, capture, comparator and pins
module desl_far_model (
   input  wire       aclk,
   input  wire [5:0] lvl,
   output logic [5:0] src
);
   timeunit 1ns;
   timeprecision 1ps;
   // on-chip logic moves only after an edge; pins are synchronised inside anyway
   always @(posedge aclk) begin
      src <= lvl;
   end
endmodule

// ==== bench/desl_top_test.sv ====
// self-checking bench for the edge select block
module desl_top_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic aclk = 0, aresetn = 0, awv = 0, wv = 0, bready = 0, arv = 0, rready = 0, p;
   logic [3:0] addr = 4'h0;
   logic [31:0] wdata = 32'h0, rdata, d;
   logic [1:0] bresp, rresp, r;
   logic [5:0] lvl = 6'h3F, src;
   logic [15:0] c;
   wire awready, wready, bvalid, arready, rvalid, ff1, ff2;
   int bad_count = 0, check_count = 0;
   int sx[2][4] = '{'{0, 1, 5, 4}, '{2, 1, 4, 3}};
   int cd[2][4] = '{'{0, 1, 2, 3}, '{0, 1, 3, 4}};
   always #12.5 aclk = ~aclk;
   desl_far_model u_desl_far_model (.aclk(aclk), .lvl(lvl), .src(src));
   desl_top u_desl_top (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(addr), .s_axi_awvalid(awv),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'h3), .s_axi_wvalid(wv),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(addr), .s_axi_arvalid(arv), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .timer_one_out(src[0]),
      .output_compare_one(src[1]), .input_capture_one(src[2]), .comparator_one(src[3]),
      .ext_edge_pin_one(src[4]), .ext_edge_pin_two(src[5]), .first_event_flag(ff1), .second_event_flag(ff2));
   // expected register image from control fields and flags
   function automatic logic [31:0] ex(input logic [15:0] v, input logic f1, input logic f2);
      ex = {16'h0000, v[15:10], f2, f1, v[7:2], 2'b00};
   endfunction
   task chk(input logic [31:0] g, input logic [31:0] e);
      check_count++;
      if (g !== e) begin
         bad_count++;
         $display("[ERR] %0t got %h expected %h", $time, g, e);
      end
   endtask
   task chk_resp(input logic [1:0] g, input logic [1:0] e);
      check_count++;
      if (g !== e) begin
         bad_count++;
         $display("[ERR] %0t resp %h expected %h", $time, g, e);
      end
   endtask
   // flag pins must agree with the flag bits of the register image
   task chk_flag(input logic [1:0] g, input logic [1:0] e);
      check_count++;
      if (g !== e) begin
         bad_count++;
         $display("[ERR] %0t flags %b expected %b", $time, g, e);
      end
   endtask
   // write and read one word; handshake waits are cut only by the watchdog
   task wr(input logic [3:0] a, input logic [15:0] v, input logic [1:0] e);
      @(posedge aclk);
      addr <= a;
      wdata <= {16'h0000, v};
      awv <= 1'b1;
      wv <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (awready) awv <= 1'b0;
         if (wready) wv <= 1'b0;
      end while (bvalid !== 1'b1);
      bready <= 1'b0;
      chk_resp(bresp, e);
   endtask
   task rc(input logic [3:0] a, input logic [31:0] e, input logic [1:0] er);
      @(posedge aclk);
      addr <= a;
      arv <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (arready) arv <= 1'b0;
      end while (rvalid !== 1'b1);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
      chk(d, e);
      chk_resp(r, er);
      if (a == 4'h0) chk_flag({ff2, ff1}, e[9:8]);
   endtask
   task complete_run;
      $display("bad_count=%0d check_count=%0d", bad_count, check_count);
      if (bad_count == 0 && check_count > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   initial begin
      repeat (5000) @(posedge aclk);
      bad_count++;
      complete_run;
   end
   initial begin
      void'($urandom(36397));
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      rc(4'h0, 32'h0, 2'h0);
      wr(4'h0, 16'hFFFF, 2'h0);
      rc(4'h0, 32'hFFFC, 2'h0);
      wr(4'h0, 16'hFCFC, 2'h0);
      rc(4'h0, 32'hFCFC, 2'h0);
      wr(4'h4, 16'h0000, 2'h2);
      rc(4'h8, 32'h0, 2'h2);
      rc(4'h0, 32'hFCFC, 2'h0);
      // every source code of both channels, random polarity, edge mode
      for (int ch = 0; ch < 2; ch++) for (int i = 0; i < 4; i++) begin
         p = $urandom % 2;
         c = ch ? {6'h3F, 2'b00, 1'b1, p, cd[1][i][3:0], 2'b00} : {1'b1, p, cd[0][i][3:0], 2'b00, 8'hFC};
         lvl <= {6{~p}};
         repeat (6) @(posedge aclk);
         wr(4'h0, c, 2'h0);
         rc(4'h0, ex(c, 1'b0, 1'b0), 2'h0);
         lvl[sx[ch][i]] <= p;
         repeat (6) @(posedge aclk);
         rc(4'h0, ex(c, ch == 0, ch == 1), 2'h0);
         wr(4'h0, c, 2'h0);
         rc(4'h0, ex(c, 1'b0, 1'b0), 2'h0);
      end
      // level mode, negative polarity: a held low level keeps setting the flag
      lvl <= 6'h3F;
      repeat (6) @(posedge aclk);
      wr(4'h0, 16'h0CFC, 2'h0);
      // the old source's stale low sample may set the flag once; clear it after settling
      repeat (6) @(posedge aclk);
      wr(4'h0, 16'h0CFC, 2'h0);
      rc(4'h0, 32'h0CFC, 2'h0);
      lvl[4] <= 1'b0;
      repeat (6) @(posedge aclk);
      wr(4'h0, 16'h0CFC, 2'h0);
      rc(4'h0, 32'h0DFC, 2'h0);
      complete_run;
   end
endmodule
